// ### design/smt_pkg.sv
package smt_pkg;

    // ----------------------------------------------------------------
    // Operation codes
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        SMT_OP_CTL_TO_REG  = 5'h00,
        SMT_OP_REG_TO_CTL  = 5'h01,
        SMT_OP_MRM_LD_W    = 5'h02,
        SMT_OP_MRM_ST_W    = 5'h03,
        SMT_OP_MRM_LD_L    = 5'h04,
        SMT_OP_MRM_ST_L    = 5'h05,
        SMT_OP_PLM_ST_W    = 5'h06,
        SMT_OP_PLM_LD_W    = 5'h07,
        SMT_OP_PLM_ST_L    = 5'h08,
        SMT_OP_PLM_LD_L    = 5'h09,
        SMT_OP_ASM_LD      = 5'h0a,
        SMT_OP_ASM_ST      = 5'h0b,
        SMT_OP_BOUNDS_CMP  = 5'h0c,
        SMT_OP_LONG_MUL    = 5'h0d,
        SMT_OP_LONG_UDIV   = 5'h0e,
        SMT_OP_LONG_SDIV   = 5'h0f,
        SMT_OP_TABLE_INTP  = 5'h10
    } smt_op_e;

    typedef enum logic [1:0] {
        SMT_CR_USER_STACK_POINTER = 2'h0,
        SMT_CR_VECTOR_BASE_REG    = 2'h1,
        SMT_CR_SOURCE_FC          = 2'h2,
        SMT_CR_DEST_FC            = 2'h3
    } smt_cr_e;

    // ----------------------------------------------------------------
    // Cycle figures at two-clock bus cycles
    // ----------------------------------------------------------------
    localparam logic [7:0] SMT_SAVE_CYC       = 8'h03;
    localparam logic [7:0] SMT_SAVE_HEAD      = 8'h01;
    localparam logic [7:0] SMT_ASM_LD_CYC     = 8'h0b;
    localparam logic [7:0] SMT_ASM_ST_CYC     = 8'h0c;
    localparam logic [7:0] SMT_ASM_HEAD_LD    = 8'h07;
    localparam logic [7:0] SMT_ASM_HEAD_ST    = 8'h09;
    localparam logic [7:0] SMT_CTL_TO_REG_CYC = 8'h0e;
    localparam logic [7:0] SMT_REG_TO_CTL_CYC = 8'h0e;
    localparam logic [7:0] SMT_CTL_HEAD_RD    = 8'h0a;
    localparam logic [7:0] SMT_CTL_HEAD_WR    = 8'h0c;
    localparam logic [7:0] SMT_MRM_W_BASE     = 8'h08;
    localparam logic [7:0] SMT_MRM_LD_L_BASE  = 8'h0c;
    localparam logic [7:0] SMT_MRM_ST_L_BASE  = 8'h0a;
    localparam logic [7:0] SMT_MRM_PER_REG    = 8'h04;
    localparam logic [7:0] SMT_PLM_ST_W_CYC   = 8'h0a;
    localparam logic [7:0] SMT_PLM_ST_L_CYC   = 8'h0e;
    localparam logic [7:0] SMT_PLM_LD_W_CYC   = 8'h0b;
    localparam logic [7:0] SMT_PLM_LD_L_CYC   = 8'h13;
    localparam logic [7:0] SMT_BCMP_CYC       = 8'h12;
    localparam logic [7:0] SMT_LMUL_CYC       = 8'h34;
    localparam logic [7:0] SMT_UDIV_MAX_CYC   = 8'h2e;
    localparam logic [7:0] SMT_SDIV_MAX_CYC   = 8'h3e;
    localparam logic [7:0] SMT_TBL_CYC        = 8'h23;
    localparam logic [7:0] SMT_OP_HEAD        = 8'h02;
    localparam logic [7:0] SMT_LONG_EXTRA     = 8'h02;
    localparam logic [7:0] SMT_BUS_NOM_CLK    = 8'h02;
    localparam logic [7:0] SMT_MRM_BUS_ALLOW  = 8'h04;
    localparam logic [7:0] SMT_CNT_RST        = 8'h00;

endpackage

// ### design/smt_cost_rom.sv
`timescale 1ns/1ps
// Nominal cost table: total cycles, head, and bus counts (r/w) per operation
module smt_cost_rom
    import smt_pkg::*;
(
    // Clock
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // Lookup
    input  wire smt_op_e    op_i,
    input  wire logic [3:0] nreg_i,
    input  wire logic       long_i,
    output logic [7:0]      cyc_o,
    output logic [7:0]      head_o,
    output logic [5:0]      rd_o,
    output logic [5:0]      wr_o
);

    // ----------------------------------------------------------------
    // Per-register cost
    // ----------------------------------------------------------------
    function automatic logic [7:0] mrm_cost(input logic [7:0] base, input logic [3:0] n);
        mrm_cost = base + 8'({n, 2'b00});
    endfunction

    logic [7:0] nxt_cyc;
    logic [7:0] nxt_head;
    logic [5:0] nxt_rd;
    logic [5:0] nxt_wr;
    logic [7:0] x_add;
    logic [5:0] x_cnt;

    always_comb begin
        // Long operand: two bus cycles and two more clocks
        x_add    = long_i ? SMT_LONG_EXTRA : 8'h00;
        x_cnt    = long_i ? 6'h02 : 6'h01;
        nxt_cyc  = 8'h00;
        nxt_head = SMT_OP_HEAD;
        nxt_rd   = 6'h00;
        nxt_wr   = 6'h00;
        unique case (op_i)
            SMT_OP_CTL_TO_REG: begin
                nxt_cyc  = SMT_CTL_TO_REG_CYC;
                nxt_head = SMT_CTL_HEAD_RD;
            end
            SMT_OP_REG_TO_CTL: begin
                nxt_cyc  = SMT_REG_TO_CTL_CYC;
                nxt_head = SMT_CTL_HEAD_WR;
            end
            SMT_OP_MRM_LD_W: begin
                nxt_cyc = mrm_cost(SMT_MRM_W_BASE, nreg_i);
                nxt_rd  = 6'({2'b00, nreg_i}) + 6'h01;
            end
            SMT_OP_MRM_ST_W: begin
                nxt_cyc = mrm_cost(SMT_MRM_W_BASE, nreg_i);
                nxt_wr  = 6'({2'b00, nreg_i});
            end
            SMT_OP_MRM_LD_L: begin
                nxt_cyc = mrm_cost(SMT_MRM_LD_L_BASE, nreg_i);
                nxt_rd  = 6'({1'b0, nreg_i, 1'b0}) + 6'h02;
            end
            SMT_OP_MRM_ST_L: begin
                nxt_cyc = mrm_cost(SMT_MRM_ST_L_BASE, nreg_i);
                nxt_wr  = 6'({1'b0, nreg_i, 1'b0});
            end
            SMT_OP_PLM_ST_W: begin
                nxt_cyc = SMT_PLM_ST_W_CYC;
                nxt_wr  = 6'h02;
            end
            SMT_OP_PLM_ST_L: begin
                nxt_cyc = SMT_PLM_ST_L_CYC;
                nxt_wr  = 6'h04;
            end
            SMT_OP_PLM_LD_W: begin
                nxt_cyc = SMT_PLM_LD_W_CYC;
                nxt_rd  = 6'h02;
            end
            SMT_OP_PLM_LD_L: begin
                nxt_cyc = SMT_PLM_LD_L_CYC;
                nxt_rd  = 6'h04;
            end
            SMT_OP_ASM_LD: begin
                nxt_cyc  = SMT_ASM_LD_CYC + x_add;
                nxt_head = SMT_ASM_HEAD_LD;
                nxt_rd   = x_cnt;
            end
            SMT_OP_ASM_ST: begin
                nxt_cyc  = SMT_ASM_ST_CYC + x_add;
                nxt_head = SMT_ASM_HEAD_ST;
                nxt_wr   = x_cnt;
            end
            SMT_OP_BOUNDS_CMP: begin
                nxt_cyc = SMT_BCMP_CYC + x_add;
                nxt_rd  = x_cnt;
            end
            // Multiply: same figure for signed and unsigned; the two divide bounds differ
            SMT_OP_LONG_MUL:  nxt_cyc = SMT_LMUL_CYC;
            SMT_OP_LONG_UDIV: nxt_cyc = SMT_UDIV_MAX_CYC;
            SMT_OP_LONG_SDIV: nxt_cyc = SMT_SDIV_MAX_CYC;
            SMT_OP_TABLE_INTP: begin
                nxt_cyc = SMT_TBL_CYC + x_add + x_add;
                nxt_rd  = 6'(x_cnt + x_cnt);
            end
            default: begin
                nxt_cyc = SMT_BUS_NOM_CLK;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cyc_o  <= SMT_CNT_RST;
            head_o <= SMT_CNT_RST;
            rd_o   <= 6'h00;
            wr_o   <= 6'h00;
        end else begin
            cyc_o  <= nxt_cyc;
            head_o <= nxt_head;
            rd_o   <= nxt_rd;
            wr_o   <= nxt_wr;
        end
    end

endmodule

// ### design/smt_ctl_reg.sv
`timescale 1ns/1ps
// Four control registers reached by the control-register move
module smt_ctl_reg
    import smt_pkg::*;
#(
    parameter int W = 32
) (
    // Clock
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    // Access
    input  wire logic         wr_i,
    input  wire smt_cr_e      sel_i,
    input  wire logic [W-1:0] wdata_i,
    output logic [W-1:0]      rdata_o
);

    logic [W-1:0] mem_ff [4];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 4; i++) begin
                mem_ff[i] <= '0;
            end
        end else if (wr_i) begin
            mem_ff[sel_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem_ff[sel_i];
        end
    end

endmodule

// ### design/smt_exec_timing.sv
`timescale 1ns/1ps
// Contract
// - Totals include operand read, prefetch and write bus cycles within them.
// - Nominal counts assume two-clock bus cycles; slower cycles lengthen execution.
// - Long operand uses two bus cycles, adding two clocks to tail and total.
// - Multi-register move tolerates bus cycles up to four clocks at no cost.
// - Alternate-space move: save 3, address, then op 11 load or 12 store.
// - Control move reaches user stack, vector base, source and destination codes.
// - Word multi-register load: 8 plus 4n cycles, n+1 reads, 2 prefetches.
// - Long multi-register load: 12 plus 4n cycles, 2n+2 reads.
// - Long multi-register store: 10 plus 4n cycles, 2n writes.
// - Peripheral lane store: 10 cycles two writes word, 14 four long.
// - Peripheral lane load: 11 cycles two reads word, 19 four long.
// - Long divide counts are upper bounds: 46 unsigned, 62 signed.
// - Signed and unsigned multiply take the same time; signed divide takes longer.
// - Bounds, long multiply/divide, memory table: save 3, address, then op.
// - Skip save for long multiply and divide when source is a data register.
// - Slow-bus extra clocks eat head first, then extend tail and total.
module smt_exec_timing
    import smt_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    // Instruction issue
    input  wire logic         start_i,
    input  wire smt_op_e      op_i,
    input  wire logic [3:0]   nreg_i,
    input  wire logic         long_i,
    input  wire logic         src_dreg_i,
    input  wire logic         early_done_i,
    input  wire logic [7:0]   ea_cyc_i,
    input  wire smt_cr_e      cr_sel_i,
    input  wire logic [31:0]  cr_wdata_i,
    // Bus handshake
    input  wire logic         bus_ack_i,
    // Status
    output logic              busy_o,
    output logic              done_o,
    output logic              bus_req_o,
    output logic [1:0]        phase_o,
    output logic [7:0]        total_o,
    output logic [7:0]        head_o,
    output logic [5:0]        rd_cnt_o,
    output logic [5:0]        wr_cnt_o,
    output logic [31:0]       cr_rdata_o
);
    import smt_pkg::*;

    // ----------------------------------------------------------------
    // Sequence states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SMT_IDLE = 3'b000,
        SMT_LOOK = 3'b001,
        SMT_SAVE = 3'b010,
        SMT_ADDR = 3'b011,
        SMT_OPER = 3'b100
    } smt_state_e;

    smt_state_e  state_ff;
    smt_state_e  nxt_state;
    smt_op_e     op_ff;
    logic [3:0]  nreg_ff;
    logic        long_ff;
    logic        src_dreg_ff;
    logic [7:0]  ea_ff;
    logic [7:0]  cnt_ff;
    logic [7:0]  bus_clk_ff;
    logic [7:0]  head_left_ff;
    logic [7:0]  rom_cyc;
    logic [7:0]  rom_head;
    logic [5:0]  rom_rd;
    logic [5:0]  rom_wr;
    logic        needs_save;
    logic        stall_add;
    logic        cr_wr;
    smt_op_e     rom_op;
    logic [3:0]  rom_nreg;
    logic        rom_long;

    // ----------------------------------------------------------------
    // Cost table and control registers
    // ----------------------------------------------------------------
    // The table is registered, so while idle it looks up the pending issue;
    // its figures are then ready when the look-up state reads them
    assign rom_op   = (state_ff == SMT_IDLE) ? op_i : op_ff;
    assign rom_nreg = (state_ff == SMT_IDLE) ? nreg_i : nreg_ff;
    assign rom_long = (state_ff == SMT_IDLE) ? long_i : long_ff;

    smt_cost_rom u_rom (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .op_i   (rom_op),
        .nreg_i (rom_nreg),
        .long_i (rom_long),
        .cyc_o  (rom_cyc),
        .head_o (rom_head),
        .rd_o   (rom_rd),
        .wr_o   (rom_wr)
    );

    assign cr_wr = start_i && (state_ff == SMT_IDLE) && (op_i == SMT_OP_REG_TO_CTL);

    smt_ctl_reg #(.W(32)) u_cr (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .wr_i    (cr_wr),
        .sel_i   (cr_sel_i),
        .wdata_i (cr_wdata_i),
        .rdata_o (cr_rdata_o)
    );

    // ----------------------------------------------------------------
    // Save-step decision
    // ----------------------------------------------------------------
    function automatic logic save_needed(input smt_op_e op, input logic dreg);
        unique case (op)
            SMT_OP_ASM_LD, SMT_OP_ASM_ST, SMT_OP_BOUNDS_CMP,
            SMT_OP_TABLE_INTP:                   save_needed = 1'b1;
            SMT_OP_LONG_MUL, SMT_OP_LONG_UDIV,
            SMT_OP_LONG_SDIV:                    save_needed = !dreg;
            default:                             save_needed = 1'b0;
        endcase
    endfunction

    function automatic logic is_mrm(input smt_op_e op);
        is_mrm = (op == SMT_OP_MRM_LD_W) || (op == SMT_OP_MRM_ST_W) ||
                 (op == SMT_OP_MRM_LD_L) || (op == SMT_OP_MRM_ST_L);
    endfunction

    assign needs_save = save_needed(op_ff, src_dreg_ff);

    // ----------------------------------------------------------------
    // Slow-bus accounting
    // ----------------------------------------------------------------
    // Each clock a bus cycle runs past its nominal length (or past four clocks for the
    // multi-register move) costs one clock; the head absorbs them first.
    always_comb begin
        stall_add = 1'b0;
        if (bus_req_o && !bus_ack_i && state_ff == SMT_OPER) begin
            if (is_mrm(op_ff)) begin
                stall_add = (bus_clk_ff >= SMT_MRM_BUS_ALLOW - 8'h01);
            end else begin
                stall_add = (bus_clk_ff >= SMT_BUS_NOM_CLK - 8'h01);
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SMT_IDLE: if (start_i) nxt_state = SMT_LOOK;
            SMT_LOOK: nxt_state = needs_save ? SMT_SAVE : SMT_ADDR;
            SMT_SAVE: if (cnt_ff <= 8'h01) nxt_state = SMT_ADDR;
            SMT_ADDR: if (cnt_ff <= 8'h01) nxt_state = SMT_OPER;
            SMT_OPER: if (cnt_ff <= 8'h01 && !stall_add) nxt_state = SMT_IDLE;
            default:  nxt_state = SMT_IDLE;
        endcase
        if (state_ff == SMT_OPER && early_done_i && (op_ff == SMT_OP_LONG_UDIV ||
            op_ff == SMT_OP_LONG_SDIV)) begin
            nxt_state = SMT_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= SMT_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            op_ff       <= SMT_OP_CTL_TO_REG;
            nreg_ff     <= 4'h0;
            long_ff     <= 1'b0;
            src_dreg_ff <= 1'b0;
            ea_ff       <= SMT_CNT_RST;
        end else if (start_i && state_ff == SMT_IDLE) begin
            op_ff       <= op_i;
            nreg_ff     <= nreg_i;
            long_ff     <= long_i;
            src_dreg_ff <= src_dreg_i;
            ea_ff       <= ea_cyc_i;
        end
    end

    // Phase down-counter; a zero-length address phase still takes one clock
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= SMT_CNT_RST;
        end else if (state_ff == SMT_LOOK) begin
            cnt_ff <= needs_save ? SMT_SAVE_CYC : ((ea_ff == 8'h00) ? 8'h01 : ea_ff);
        end else if (state_ff == SMT_SAVE && cnt_ff <= 8'h01) begin
            cnt_ff <= (ea_ff == 8'h00) ? 8'h01 : ea_ff;
        end else if (state_ff == SMT_ADDR && cnt_ff <= 8'h01) begin
            // Head overlaps the prior tail, so the op starts on its own count
            cnt_ff <= rom_cyc;
        end else if (stall_add && head_left_ff == 8'h00) begin
            cnt_ff <= cnt_ff;
        end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            head_left_ff <= SMT_CNT_RST;
        end else if (state_ff == SMT_ADDR && cnt_ff <= 8'h01) begin
            head_left_ff <= rom_head;
        end else if (stall_add && head_left_ff != 8'h00) begin
            head_left_ff <= head_left_ff - 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_clk_ff <= SMT_CNT_RST;
        end else if (!bus_req_o || bus_ack_i) begin
            bus_clk_ff <= SMT_CNT_RST;
        end else if (bus_clk_ff != 8'hff) begin
            bus_clk_ff <= bus_clk_ff + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
            bus_req_o <= 1'b0;
            phase_o   <= 2'h0;
        end else begin
            busy_o    <= (nxt_state != SMT_IDLE);
            done_o    <= (state_ff == SMT_OPER) && (nxt_state == SMT_IDLE);
            bus_req_o <= (nxt_state == SMT_OPER);
            phase_o   <= nxt_state[2] ? 2'h3 : nxt_state[1:0];
        end
    end

    // Total reported includes save, address and op; r/p/w are inside it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            total_o  <= SMT_CNT_RST;
            head_o   <= SMT_CNT_RST;
            rd_cnt_o <= 6'h00;
            wr_cnt_o <= 6'h00;
        end else if (state_ff == SMT_LOOK) begin
            total_o  <= 8'(rom_cyc + ea_ff + (needs_save ? SMT_SAVE_CYC : 8'h00));
            head_o   <= needs_save ? SMT_SAVE_HEAD : rom_head;
            rd_cnt_o <= rom_rd;
            wr_cnt_o <= rom_wr;
        end else if (stall_add && head_left_ff == 8'h00) begin
            total_o  <= total_o + 8'h01;
        end
    end

endmodule

// ### bench/smt_exec_timing_monitor.sv
`timescale 1ns/1ps
module smt_exec_timing_monitor
    import smt_pkg::*;
(
    // Clock
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // Watched ports
    input  wire logic       start_i,
    input  wire smt_op_e    op_i,
    input  wire logic       src_dreg_i,
    input  wire logic       busy_o,
    input  wire logic       done_o,
    input  wire logic       bus_req_o,
    input  wire logic [1:0] phase_o,
    input  wire logic [7:0] total_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic take;
    assign take = start_i && !busy_o;
    done_one_cycle_a: assert property (done_o |=> !done_o)
        else $error("done held past one cycle");
    busy_needs_done_a: assert property ($fell(busy_o) |-> done_o)
        else $error("busy dropped without done");
    done_ends_busy_a: assert property (done_o |-> !busy_o && $past(busy_o))
        else $error("done outside an instruction");
    issue_taken_a: assert property (take |=> busy_o && phase_o == 2'h1)
        else $error("issue not taken");
    bus_in_op_a: assert property (bus_req_o |-> busy_o && phase_o == 2'h3)
        else $error("bus request outside op phase");
    save_three_a: assert property ($rose(phase_o == 2'h2) |->
        (phase_o == 2'h2) [*3] ##1 phase_o == 2'h3)
        else $error("save step not three cycles");
    save_skipped_a: assert property (take && op_i == SMT_OP_LONG_MUL && src_dreg_i
        |=> ##1 phase_o == 2'h3)
        else $error("save not skipped");
    save_kept_a: assert property (take && op_i inside {SMT_OP_BOUNDS_CMP, SMT_OP_ASM_LD,
        SMT_OP_ASM_ST} |=> ##1 phase_o == 2'h2)
        else $error("save step missing");
    total_holds_a: assert property (!busy_o && !take |=> $stable(total_o))
        else $error("total changed while idle");
    busy_bound_a: assert property ($rose(busy_o) |-> ##[1:300] !busy_o)
        else $error("instruction never ended");
    back_to_back_c: cover property (done_o && take);
    save_step_c: cover property (phase_o == 2'h2);
    bus_stall_c: cover property (bus_req_o [*6]);
endmodule
bind smt_exec_timing smt_exec_timing_monitor i_mon (.clk_i(clk_i), .rstn_i(rstn_i),
    .start_i(start_i), .op_i(op_i), .src_dreg_i(src_dreg_i), .busy_o(busy_o),
    .done_o(done_o), .bus_req_o(bus_req_o), .phase_o(phase_o), .total_o(total_o));

// ### bench/smt_bus_model.sv
`timescale 1ns/1ps
// Far-side bus: ends each bus cycle after wait_i clocks while requested
module smt_bus_model (
    // Clock
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    // Bus
    input  wire logic       bus_req_i,
    input  wire logic [3:0] wait_i,
    output logic            bus_ack_o
);
    logic [3:0] cnt_ff;
    // Two clocks is the nominal cycle; larger waits play a slow responder
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff    <= 4'h0;
            bus_ack_o <= 1'b0;
        end else if (!bus_req_i) begin
            cnt_ff    <= 4'h0;
            bus_ack_o <= 1'b0;
        end else begin
            cnt_ff    <= bus_ack_o ? 4'h0 : cnt_ff + 4'h1;
            bus_ack_o <= !bus_ack_o && (cnt_ff == wait_i - 4'h2);
        end
    end
endmodule

// ### bench/smt_exec_timing_tb.sv
`timescale 1ns/1ps
module smt_exec_timing_tb;
    import smt_pkg::*;
    typedef struct {
        smt_op_e    op;
        logic [3:0] n;
        logic       lng;
        logic       dreg;
        logic [7:0] tot;
        logic [5:0] rd;
        logic [5:0] wr;
    } smt_tb_row_s;
    logic clk_i = 1'b0, rstn_i = 1'b0, start_i = 1'b0, long_i = 1'b0, src_dreg_i = 1'b0;
    logic early_done_i = 1'b0, bus_ack, busy_o, done_o, bus_req_o;
    logic [3:0] nreg_i = 4'h0, bus_wait = 4'h2;
    logic [7:0] ea_cyc_i = 8'h02, total_o, head_o;
    logic [5:0] rd_cnt_o, wr_cnt_o;
    logic [1:0] phase_o;
    logic [31:0] cr_wdata_i = 32'h0, cr_rdata_o;
    smt_op_e op_i = SMT_OP_CTL_TO_REG;
    smt_cr_e cr_sel_i = SMT_CR_USER_STACK_POINTER;
    int errors = 0, checked = 0, lat;
    // Address step fixed at two clocks, already folded into each total
    smt_tb_row_s rows [20] = '{
        '{SMT_OP_MRM_LD_W, 4'h3, 1'b0, 1'b0, 8'h16, 6'h04, 6'h00},
        '{SMT_OP_MRM_LD_W, 4'h0, 1'b0, 1'b0, 8'h0a, 6'h01, 6'h00},
        '{SMT_OP_MRM_ST_W, 4'h2, 1'b0, 1'b0, 8'h12, 6'h00, 6'h02},
        '{SMT_OP_MRM_LD_L, 4'h5, 1'b0, 1'b0, 8'h22, 6'h0c, 6'h00},
        '{SMT_OP_MRM_ST_L, 4'hf, 1'b0, 1'b0, 8'h48, 6'h00, 6'h1e},
        '{SMT_OP_PLM_ST_W, 4'h0, 1'b0, 1'b0, 8'h0c, 6'h00, 6'h02},
        '{SMT_OP_PLM_ST_L, 4'h0, 1'b0, 1'b0, 8'h10, 6'h00, 6'h04},
        '{SMT_OP_PLM_LD_W, 4'h0, 1'b0, 1'b0, 8'h0d, 6'h02, 6'h00},
        '{SMT_OP_PLM_LD_L, 4'h0, 1'b0, 1'b0, 8'h15, 6'h04, 6'h00},
        '{SMT_OP_ASM_LD, 4'h0, 1'b0, 1'b0, 8'h10, 6'h01, 6'h00},
        '{SMT_OP_ASM_LD, 4'h0, 1'b1, 1'b0, 8'h12, 6'h02, 6'h00},
        '{SMT_OP_ASM_ST, 4'h0, 1'b0, 1'b0, 8'h11, 6'h00, 6'h01},
        '{SMT_OP_ASM_ST, 4'h0, 1'b1, 1'b0, 8'h13, 6'h00, 6'h02},
        '{SMT_OP_BOUNDS_CMP, 4'h0, 1'b0, 1'b0, 8'h17, 6'h01, 6'h00},
        '{SMT_OP_LONG_MUL, 4'h0, 1'b0, 1'b0, 8'h39, 6'h00, 6'h00},
        '{SMT_OP_LONG_MUL, 4'h0, 1'b0, 1'b1, 8'h36, 6'h00, 6'h00},
        '{SMT_OP_LONG_UDIV, 4'h0, 1'b0, 1'b0, 8'h33, 6'h00, 6'h00},
        '{SMT_OP_LONG_SDIV, 4'h0, 1'b0, 1'b0, 8'h43, 6'h00, 6'h00},
        '{SMT_OP_TABLE_INTP, 4'h0, 1'b0, 1'b0, 8'h28, 6'h02, 6'h00},
        '{SMT_OP_LONG_UDIV, 4'h0, 1'b0, 1'b1, 8'h30, 6'h00, 6'h00}
    };
    always #20 clk_i = ~clk_i;
    smt_exec_timing i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i), .op_i(op_i),
        .nreg_i(nreg_i), .long_i(long_i), .src_dreg_i(src_dreg_i),
        .early_done_i(early_done_i), .ea_cyc_i(ea_cyc_i), .cr_sel_i(cr_sel_i),
        .cr_wdata_i(cr_wdata_i), .bus_ack_i(bus_ack), .busy_o(busy_o), .done_o(done_o),
        .bus_req_o(bus_req_o), .phase_o(phase_o), .total_o(total_o), .head_o(head_o),
        .rd_cnt_o(rd_cnt_o), .wr_cnt_o(wr_cnt_o), .cr_rdata_o(cr_rdata_o));
    smt_bus_model i_bus (.clk_i(clk_i), .rstn_i(rstn_i), .bus_req_i(bus_req_o),
        .wait_i(bus_wait), .bus_ack_o(bus_ack));
    // ----------------------------------------------------------------
    // Checking and issue tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        if (errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cmp_cnt(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_dat(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Called at a falling edge; returns there in the done cycle, so issues run back to back
    task automatic issue(input smt_op_e op, input logic [3:0] n, input logic lng,
                         input logic dreg, input logic poke);
        op_i = op;
        nreg_i = n;
        long_i = lng;
        src_dreg_i = dreg;
        start_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
        for (lat = 0; lat < 400 && done_o !== 1'b1; lat++) begin
            @(negedge clk_i);
            start_i = poke && lat == 2;
            if (poke && lat == 2) op_i = SMT_OP_MRM_ST_L;
        end
        if (done_o !== 1'b1) begin
            errors++;
            print_verdict();
        end
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(negedge clk_i);
        cmp_cnt("busy in reset", 8'h00, {7'h0, busy_o});
        cmp_cnt("total in reset", 8'h00, total_o);
        rstn_i = 1'b1;
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].n, rows[i].lng, rows[i].dreg, 1'b0);
            cmp_cnt("total", rows[i].tot, total_o);
            cmp_cnt("reads", {2'h0, rows[i].rd}, {2'h0, rd_cnt_o});
            cmp_cnt("writes", {2'h0, rows[i].wr}, {2'h0, wr_cnt_o});
            cmp_cnt("latency", rows[i].tot + 8'h01, 8'(lat));
        end
        for (int s = 0; s < 4; s++) begin
            cr_sel_i = smt_cr_e'(s);
            cr_wdata_i = {30'h2b5ac3e1, s[1:0]};
            issue(SMT_OP_REG_TO_CTL, 4'h0, 1'b0, 1'b0, 1'b0);
        end
        for (int s = 0; s < 4; s++) begin
            cr_sel_i = smt_cr_e'(s);
            repeat (2) @(negedge clk_i);
            cmp_dat("control reg", {30'h2b5ac3e1, s[1:0]}, cr_rdata_o);
        end
        issue(SMT_OP_PLM_ST_W, 4'h0, 1'b0, 1'b0, 1'b1);
        cmp_cnt("refused total", 8'h0c, total_o);
        repeat (3) @(negedge clk_i);
        cmp_cnt("refused idle", 8'h00, {7'h0, busy_o});
        early_done_i = 1'b1;
        issue(SMT_OP_LONG_SDIV, 4'h0, 1'b0, 1'b0, 1'b0);
        cmp_cnt("early divide", 8'h01, {7'h0, lat < 69});
        issue(SMT_OP_LONG_MUL, 4'h0, 1'b0, 1'b0, 1'b0);
        cmp_cnt("multiply latency", 8'h3a, 8'(lat));
        early_done_i = 1'b0;
        bus_wait = 4'h4;
        issue(SMT_OP_MRM_LD_L, 4'h2, 1'b0, 1'b0, 1'b0);
        cmp_cnt("slow move total", 8'h16, total_o);
        cmp_cnt("slow move latency", 8'h17, 8'(lat));
        bus_wait = 4'h8;
        issue(SMT_OP_PLM_LD_L, 4'h0, 1'b0, 1'b0, 1'b0);
        cmp_cnt("slow bus grows", 8'h01, {7'h0, total_o > 8'h15});
        cmp_cnt("slow bus latency", total_o + 8'h01, 8'(lat));
        bus_wait = 4'h2;
        op_i = SMT_OP_MRM_ST_L;
        nreg_i = 4'hf;
        start_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
        repeat (5) @(negedge clk_i);
        rstn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        cmp_cnt("busy after reset", 8'h00, {7'h0, busy_o});
        cmp_cnt("done after reset", 8'h00, {7'h0, done_o});
        rstn_i = 1'b1;
        issue(SMT_OP_PLM_LD_W, 4'h0, 1'b0, 1'b0, 1'b0);
        cmp_cnt("total after reset", 8'h0d, total_o);
        cmp_cnt("head", SMT_OP_HEAD, head_o);
        print_verdict();
    end
endmodule
